/* File: include/wdl_pkg.sv */
// Constants and carrier types for the watchdog and power LED block
package wdl_pkg;
   // Clock and unit timing
   localparam int unsigned CLK_MHZ       = 125;
   localparam int unsigned BLINK_HALF_MS = 500;
   localparam int unsigned HALF_CYC      = BLINK_HALF_MS * 1000 * CLK_MHZ;
   localparam int unsigned HALVES_SEC    = 2;
   localparam int unsigned SEC_PER_MIN   = 60;
   localparam int unsigned PRE_W         = 27;
   localparam int unsigned SEC_W         = 6;
   localparam logic [SEC_W-1:0] SEC_LAST = 6'h3b;

   // Reload value and event decode
   localparam logic [7:0]  RELOAD_RST = 8'h00;
   localparam logic [15:0] JOY_PORT   = 16'h0201;

   // Control word bit positions
   localparam int unsigned CTRL_STATUS = 0;
   localparam int unsigned CTRL_TOGGLE = 1;
   localparam int unsigned CTRL_FORCE  = 2;

   // Pin configuration fields
   localparam int unsigned PCFG_DIR   = 0;
   localparam int unsigned PCFG_POL   = 1;
   localparam int unsigned PCFG_FN_LO = 3;
   localparam int unsigned PCFG_FN_HI = 4;
   localparam int unsigned PCFG_OTYPE = 7;
   localparam logic [1:0]  FN_GPIO    = 2'h0;
   localparam logic [1:0]  FN_LED     = 2'h1;

   // LED data bit positions in the two port data registers
   localparam int unsigned PORT1_LED_BIT = 3;
   localparam int unsigned PORT6_LED_BIT = 1;

   // Interrupt channels; select 0 means not mapped
   localparam int unsigned IRQ_N = 16;

   typedef struct packed {
      logic       unit_minutes;
      logic       kbd_en;
      logic       mouse_en;
      logic       joy_en;
      logic       led_tog_on_to;
      logic       irq_en;
      logic [3:0] irq_sel;
   } wdl_cfg_s;

   typedef struct packed {
      logic out;
      logic oe;
   } wdl_pin_s;
endpackage

/* File: rtl/wdl_top.sv */
// Watchdog countdown timer with power LED driver
// How it works
// - Count 1..255 units, minutes or seconds
// - Reload zero disables; resets to zero
// - Non-zero reload write loads and starts counting
// - At zero counter stops, status set
// - Host may write status bit anytime
// - Keyboard, mouse, port access events, each enabled
// - Enabled event reloads counter, clears status
// - Interrupt rises with status when enabled
// - Mapped interrupt line follows status level
// - Force bit zeroes count, sets status, self-clears
// - LED on one pin only
// - LED pin stays input after reset
// - Polarity bit picks active high or low
// - Data bit set turns LED on
// - Blink at 1 Hz, half duty
// - Toggle only in LED alternate function
// - Control toggle bit blinks unconditionally
// - Toggle on timeout blinks while status set
// - Output type bit picks open drain/push-pull
`timescale 1ns/1ps
module wdl_top #(
   parameter int unsigned HALF_CYCLES = wdl_pkg::HALF_CYC
) (
   // Clock and reset
   input  wire logic                        i_mclk,
   input  wire logic                        i_reset,
   // Watchdog configuration and unit select
   input  wire wdl_pkg::wdl_cfg_s           i_watchdog_config_reg,
   // Reload value write
   input  wire logic                        i_reload_wr,
   input  wire logic [7:0]                  i_watchdog_reload_value,
   // Control register write
   input  wire logic                        i_ctrl_wr,
   input  wire logic [7:0]                  i_ctrl_wdata,
   // Reload events
   input  wire logic                        i_kbd_irq,
   input  wire logic                        i_mouse_irq,
   input  wire logic                        i_io_access,
   input  wire logic [15:0]                 i_io_addr,
   // LED pin configuration and data
   input  wire logic [7:0]                  i_led_pin_a_cfg,
   input  wire logic [7:0]                  i_led_pin_b_cfg,
   input  wire logic [7:0]                  i_port_one_data_reg,
   input  wire logic [7:0]                  i_port_six_data_reg,
   // Status and counter
   output logic [7:0]                       o_watchdog_counter,
   output logic [7:0]                       o_watchdog_control_reg,
   output logic                             o_timeout_status,
   // Interrupt requests
   output logic [wdl_pkg::IRQ_N-1:0]        o_irq,
   // LED pins
   output wdl_pkg::wdl_pin_s                o_led_pin_a,
   output wdl_pkg::wdl_pin_s                o_led_pin_b
);
   import wdl_pkg::*;

   localparam logic [PRE_W-1:0] HALF_LAST = PRE_W'(HALF_CYCLES - 1);

   typedef struct packed {
      logic [7:0]       count;
      logic [7:0]       reload;
      logic             status;
      logic             led_tog;
      logic [PRE_W-1:0] pre;
      logic [PRE_W-1:0] blink_pre;
      logic             half;
      logic [SEC_W-1:0] sec;
      logic             phase;
      logic             kbd_q;
      logic             mouse_q;
      logic [IRQ_N-1:0] irq;
      wdl_pin_s         pin_a;
      wdl_pin_s         pin_b;
   } wdl_state_s;

   wdl_state_s st_r;
   wdl_state_s st_nxt;

   logic     half_tick;
   logic     blink_tick;
   logic     unit_tick;
   logic     ev_hit;
   logic     expire;
   logic     blink;
   wdl_pin_s pin_a_nxt;
   wdl_pin_s pin_b_nxt;

   // Blink comes from registered state and the config input only, so the pin drivers form no loop
   assign blink = st_r.led_tog || (i_watchdog_config_reg.led_tog_on_to && st_r.status);

   wdl_pin_drv #(
      .CFG_W(8)
   ) u_pin_a (
      .i_cfg      (i_led_pin_a_cfg),
      .i_data     (i_port_one_data_reg[PORT1_LED_BIT]),
      .i_led_ok   (1'b1),
      .i_blink_en (blink),
      .i_phase    (st_r.phase),
      .o_pin      (pin_a_nxt)
   );

   // Pin b loses the LED function when pin a already holds it
   wdl_pin_drv #(
      .CFG_W(8)
   ) u_pin_b (
      .i_cfg      (i_led_pin_b_cfg),
      .i_data     (i_port_six_data_reg[PORT6_LED_BIT]),
      .i_led_ok   (i_led_pin_a_cfg[PCFG_FN_HI:PCFG_FN_LO] != FN_LED),
      .i_blink_en (blink),
      .i_phase    (st_r.phase),
      .o_pin      (pin_b_nxt)
   );

   always_comb begin
      st_nxt = st_r;
      // Half-second prescaler for count units only; blink has its own
      half_tick = (st_r.pre == HALF_LAST);
      unit_tick = half_tick && st_r.half
                  && (!i_watchdog_config_reg.unit_minutes || st_r.sec == SEC_LAST);
      ev_hit = (i_watchdog_config_reg.kbd_en && i_kbd_irq && !st_r.kbd_q)
               || (i_watchdog_config_reg.mouse_en && i_mouse_irq && !st_r.mouse_q)
               || (i_watchdog_config_reg.joy_en && i_io_access && i_io_addr == JOY_PORT);
      expire = unit_tick && st_r.count == 8'h01;
      st_nxt.kbd_q   = i_kbd_irq;
      st_nxt.mouse_q = i_mouse_irq;
      st_nxt.pre     = half_tick ? '0 : st_r.pre + 1'b1;
      // Blink timebase runs free, so host writes never stretch a half period
      blink_tick       = (st_r.blink_pre == HALF_LAST);
      st_nxt.blink_pre = blink_tick ? '0 : st_r.blink_pre + 1'b1;
      if (blink_tick) begin
         st_nxt.phase = !st_r.phase;
      end
      if (half_tick) begin
         st_nxt.half  = !st_r.half;
         if (st_r.half) begin
            st_nxt.sec = (st_r.sec == SEC_LAST) ? '0 : st_r.sec + 1'b1;
         end
      end
      if (st_r.count != 8'h00 && unit_tick) begin
         st_nxt.count = st_r.count - 1'b1;
      end
      if (i_ctrl_wr) begin
         st_nxt.status  = i_ctrl_wdata[CTRL_STATUS];
         st_nxt.led_tog = i_ctrl_wdata[CTRL_TOGGLE];
      end
      if (ev_hit) begin
         st_nxt.count  = st_r.reload;
         st_nxt.status = 1'b0;
      end
      if (ev_hit || i_reload_wr) begin
         st_nxt.pre  = '0;
         st_nxt.half = 1'b0;
         st_nxt.sec  = '0;
      end
      if (i_reload_wr) begin
         st_nxt.reload = i_watchdog_reload_value;
         st_nxt.count  = i_watchdog_reload_value;
      end
      // Timeout set wins over a control write clear in the same cycle
      if (expire && !ev_hit && !i_reload_wr) begin
         st_nxt.status = 1'b1;
      end
      if (i_ctrl_wr && i_ctrl_wdata[CTRL_FORCE]) begin
         st_nxt.count  = 8'h00;
         st_nxt.status = 1'b1;
      end
      st_nxt.pin_a = pin_a_nxt;
      st_nxt.pin_b = pin_b_nxt;
      st_nxt.irq = '0;
      if (i_watchdog_config_reg.irq_en && i_watchdog_config_reg.irq_sel != 4'h0) begin
         st_nxt.irq[i_watchdog_config_reg.irq_sel] = st_r.status;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         st_r        <= '0;
         st_r.reload <= RELOAD_RST;
         st_r.pin_a  <= '{out: 1'b0, oe: 1'b0};
         st_r.pin_b  <= '{out: 1'b0, oe: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_watchdog_counter     = st_r.count;
   assign o_watchdog_control_reg = {5'h00, 1'b0, st_r.led_tog, st_r.status};
   assign o_timeout_status       = st_r.status;
   assign o_irq                  = st_r.irq;
   assign o_led_pin_a            = st_r.pin_a;
   assign o_led_pin_b            = st_r.pin_b;

   a_force_zero: assert property (@(posedge i_mclk) disable iff (i_reset)
      i_ctrl_wr && i_ctrl_wdata[CTRL_FORCE] |=> st_r.count == 8'h00 && st_r.status && !o_watchdog_control_reg[2])
      else $error("force did not time out");
   a_reload_load: assert property (@(posedge i_mclk) disable iff (i_reset)
      i_reload_wr && !(i_ctrl_wr && i_ctrl_wdata[CTRL_FORCE]) |=> st_r.count == $past(i_watchdog_reload_value))
      else $error("reload value not loaded");
   a_zero_idle: assert property (@(posedge i_mclk) disable iff (i_reset)
      st_r.count == 8'h00 && !i_reload_wr && !ev_hit |=> st_r.count == 8'h00)
      else $error("disabled counter moved");
   a_expire_set: assert property (@(posedge i_mclk) disable iff (i_reset)
      expire && !ev_hit && !i_reload_wr |=> st_r.status && st_r.count == 8'h00)
      else $error("expiry did not set status");
   a_status_write: assert property (@(posedge i_mclk) disable iff (i_reset)
      i_ctrl_wr && !ev_hit && !expire && !i_ctrl_wdata[CTRL_FORCE] |=> st_r.status == $past(i_ctrl_wdata[CTRL_STATUS]))
      else $error("status write lost");
   a_event_reload: assert property (@(posedge i_mclk) disable iff (i_reset)
      ev_hit && !i_reload_wr && !i_ctrl_wr |=> st_r.count == $past(st_r.reload) && !st_r.status)
      else $error("event did not reload");
   a_irq_off: assert property (@(posedge i_mclk) disable iff (i_reset)
      !i_watchdog_config_reg.irq_en |=> o_irq == '0)
      else $error("irq active while disabled");
   a_irq_level: assert property (@(posedge i_mclk) disable iff (i_reset)
      i_watchdog_config_reg.irq_en && i_watchdog_config_reg.irq_sel != 4'h0
      |=> o_irq[$past(i_watchdog_config_reg.irq_sel)] == $past(st_r.status))
      else $error("irq does not follow status");
   a_tick_count: assert property (@(posedge i_mclk) disable iff (i_reset)
      unit_tick && st_r.count > 8'h01 && !ev_hit && !i_reload_wr && !i_ctrl_wr
      |=> st_r.count == $past(st_r.count) - 8'h01)
      else $error("unit tick did not decrement");
   a_one_led: assert property (@(posedge i_mclk) disable iff (i_reset)
      i_led_pin_a_cfg[PCFG_FN_HI:PCFG_FN_LO] == FN_LED && i_led_pin_b_cfg[PCFG_FN_HI:PCFG_FN_LO] == FN_LED
      |=> !o_led_pin_b.oe)
      else $error("both pins drive the LED");

   c_expire: cover property (@(posedge i_mclk) disable iff (i_reset) expire);
   c_force: cover property (@(posedge i_mclk) disable iff (i_reset) i_ctrl_wr && i_ctrl_wdata[CTRL_FORCE]);
   c_event: cover property (@(posedge i_mclk) disable iff (i_reset) ev_hit && st_r.status);
   a_irq_rise: assert property (@(posedge i_mclk) disable iff (i_reset)
      i_watchdog_config_reg.irq_en && i_watchdog_config_reg.irq_sel != 4'h0
      && st_r.status && !$past(st_r.status)
      |=> o_irq[$past(i_watchdog_config_reg.irq_sel)])
      else $error("irq missed status rise");
   a_pin_reset: assert property (@(posedge i_mclk) disable iff (i_reset)
      $past(i_reset) |-> !o_led_pin_a.oe && !o_led_pin_b.oe)
      else $error("pin driven right after reset");
   a_open_drain: assert property (@(posedge i_mclk) disable iff (i_reset)
      !i_led_pin_a_cfg[PCFG_OTYPE] |=> !o_led_pin_a.out)
      else $error("open drain pin driven high");
   a_led_steady: assert property (@(posedge i_mclk) disable iff (i_reset)
      i_led_pin_a_cfg[PCFG_FN_HI:PCFG_FN_LO] == FN_LED && !i_led_pin_a_cfg[PCFG_POL]
      && !i_led_pin_a_cfg[PCFG_OTYPE] && !blink
      |=> o_led_pin_a.oe == $past(i_port_one_data_reg[PORT1_LED_BIT]))
      else $error("steady LED does not follow data");
   a_blink_toggle: assert property (@(posedge i_mclk) disable iff (i_reset)
      blink_tick |=> st_r.phase != $past(st_r.phase))
      else $error("blink phase did not flip");
   a_blink_hold: assert property (@(posedge i_mclk) disable iff (i_reset)
      !blink_tick |=> st_r.phase == $past(st_r.phase))
      else $error("blink phase flipped early");
   a_minute_unit: assert property (@(posedge i_mclk) disable iff (i_reset)
      unit_tick && i_watchdog_config_reg.unit_minutes |-> st_r.sec == SEC_LAST && st_r.half)
      else $error("minute tick before sixty seconds");
   a_gpio_steady: assert property (@(posedge i_mclk) disable iff (i_reset)
      i_led_pin_a_cfg[PCFG_FN_HI:PCFG_FN_LO] == FN_GPIO && $stable(i_led_pin_a_cfg) && !$past(i_reset)
      && $stable(i_port_one_data_reg[PORT1_LED_BIT]) |=> $stable(o_led_pin_a))
      else $error("pin toggles in plain function");

   c_blink: cover property (@(posedge i_mclk) disable iff (i_reset) blink && blink_tick);
   c_irq_raised: cover property (@(posedge i_mclk) disable iff (i_reset) o_irq != '0);
endmodule

// Next drive of one LED-capable pin from its configuration and data bit
module wdl_pin_drv #(
   parameter int unsigned CFG_W = 8
) (
   // Pin configuration and data bit
   input  wire logic [CFG_W-1:0] i_cfg,
   input  wire logic             i_data,
   // LED permission and blink control
   input  wire logic             i_led_ok,
   input  wire logic             i_blink_en,
   input  wire logic             i_phase,
   // Next pin drive
   output wdl_pkg::wdl_pin_s     o_pin
);
   import wdl_pkg::*;

   logic on;
   logic lvl;
   logic drv;

   always_comb begin
      o_pin = '{out: 1'b0, oe: 1'b0};
      on    = 1'b0;
      lvl   = 1'b0;
      drv   = 1'b0;
      if (i_cfg[PCFG_FN_HI:PCFG_FN_LO] == FN_LED && i_led_ok) begin
         on  = i_data && (!i_blink_en || i_phase);
         // Non-inverted sinks current, so the pin goes low for LED on
         lvl = i_cfg[PCFG_POL] ? on : !on;
         drv = 1'b1;
      end else if (i_cfg[PCFG_FN_HI:PCFG_FN_LO] == FN_GPIO && !i_cfg[PCFG_DIR]) begin
         // Plain function gives steady control only, never a blink
         lvl = i_data ^ i_cfg[PCFG_POL];
         drv = 1'b1;
      end
      if (drv) begin
         if (i_cfg[PCFG_OTYPE]) begin
            o_pin = '{out: lvl, oe: 1'b1};
         end else begin
            // Open drain only ever pulls low, which also suits standby power
            o_pin = '{out: 1'b0, oe: !lvl};
         end
      end
   end
endmodule

/* File: tb/wdl_top_tb.sv */
// Self-checking testbench for the watchdog and power LED block
`timescale 1ns/1ps
module wdl_top_tb;
   import wdl_pkg::*;
   localparam int unsigned HC = 4;
   logic             clk = 1'b0;
   logic             rst = 1'b1;
   wdl_cfg_s         cfg = '0;
   logic             rwr = 1'b0;
   logic [7:0]       rval = 8'h00;
   logic             cwr = 1'b0;
   logic [7:0]       cdat = 8'h00;
   logic             kbd = 1'b0;
   logic             mou = 1'b0;
   logic             ioa = 1'b0;
   logic [15:0]      ioad = 16'h0000;
   // Pin setup starts as input, as after a host reset
   logic [7:0]       pa_cfg = 8'h01;
   logic [7:0]       pb_cfg = 8'h01;
   logic [7:0]       d1 = 8'h00;
   logic [7:0]       d6 = 8'h00;
   logic [7:0]       cnt;
   logic [7:0]       ctl;
   logic             sts;
   logic [IRQ_N-1:0] irq;
   wdl_pin_s         pa;
   wdl_pin_s         pb;
   int               fail_count = 0;
   int               checks_done = 0;
   int               nb;

   wdl_top #(.HALF_CYCLES(HC)) dut (.i_mclk(clk), .i_reset(rst), .i_watchdog_config_reg(cfg),
      .i_reload_wr(rwr), .i_watchdog_reload_value(rval), .i_ctrl_wr(cwr), .i_ctrl_wdata(cdat),
      .i_kbd_irq(kbd), .i_mouse_irq(mou), .i_io_access(ioa), .i_io_addr(ioad),
      .i_led_pin_a_cfg(pa_cfg), .i_led_pin_b_cfg(pb_cfg), .i_port_one_data_reg(d1),
      .i_port_six_data_reg(d6), .o_watchdog_counter(cnt), .o_watchdog_control_reg(ctl),
      .o_timeout_status(sts), .o_irq(irq), .o_led_pin_a(pa), .o_led_pin_b(pb));

   always #4 clk = ~clk;

   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      checks_done++;
      if (g !== e) begin
         $display("ERROR %s expected %h seen %h", nm, e, g);
         fail_count++;
      end
   endtask

   task automatic reload(input logic [7:0] v);
      rwr = 1'b1;
      rval = v;
      cyc(1);
      rwr = 1'b0;
   endtask

   task automatic ctrl(input logic [7:0] v);
      cwr = 1'b1;
      cdat = v;
      cyc(1);
      cwr = 1'b0;
   endtask

   task automatic io(input logic [15:0] a);
      ioa = 1'b1;
      ioad = a;
      cyc(1);
      ioa = 1'b0;
   endtask

   // Bounded wait for the timeout status to rise
   task automatic wait_sts(input int lim);
      int n;
      n = 0;
      while (sts !== 1'b1 && n < lim) begin
         cyc(1);
         n++;
      end
      if (sts !== 1'b1) begin
         $display("ERROR status wait expected 1 seen %b", sts);
         fail_count++;
         results();
      end
   endtask

   // Counts changes of pin a level over sixteen cycles
   task automatic blinks(output int n);
      logic last;
      n = 0;
      cyc(3);
      last = pa.out;
      repeat (16) begin
         cyc(1);
         if (pa.out !== last) n++;
         last = pa.out;
      end
   endtask

   task automatic t_reset();
      chk("counter", 16'h0000, {8'h00, cnt});
      chk("status", 16'h0000, {15'h0000, sts});
      chk("irq", 16'h0000, irq);
      chk("pin oe", 16'h0000, {14'h0000, pa.oe, pb.oe});
      $display("test reset done");
   endtask

   task automatic t_count();
      cfg.irq_en = 1'b1;
      cfg.irq_sel = 4'h5;
      reload(8'h03);
      cyc(2);
      chk("counter", 16'h0003, {8'h00, cnt});
      cyc(8);
      chk("counter", 16'h0002, {8'h00, cnt});
      wait_sts(20);
      chk("counter", 16'h0000, {8'h00, cnt});
      cyc(2);
      chk("irq", 16'h0020, irq);
      ctrl(8'h00);
      cyc(10);
      chk("status", 16'h0000, {15'h0000, sts});
      chk("irq", 16'h0000, irq);
      chk("counter", 16'h0000, {8'h00, cnt});
      cfg.unit_minutes = 1'b1;
      reload(8'h01);
      cyc(400);
      chk("counter", 16'h0001, {8'h00, cnt});
      wait_sts(120);
      ctrl(8'h00);
      cfg.unit_minutes = 1'b0;
      $display("test count done");
   endtask

   task automatic t_events();
      cfg.kbd_en = 1'b1;
      cfg.joy_en = 1'b1;
      reload(8'h05);
      ctrl(8'h01);
      chk("status", 16'h0001, {15'h0000, sts});
      cyc(12);
      kbd = 1'b1;
      cyc(2);
      chk("counter", 16'h0005, {8'h00, cnt});
      chk("status", 16'h0000, {15'h0000, sts});
      ctrl(8'h01);
      mou = 1'b1;
      io(16'h0200);
      cyc(1);
      chk("status", 16'h0001, {15'h0000, sts});
      io(16'h0201);
      chk("status", 16'h0000, {15'h0000, sts});
      ctrl(8'h01);
      cfg.mouse_en = 1'b1;
      mou = 1'b0;
      cyc(1);
      mou = 1'b1;
      cyc(1);
      chk("status", 16'h0000, {15'h0000, sts});
      reload(8'h00);
      cyc(30);
      chk("status", 16'h0000, {15'h0000, sts});
      chk("counter", 16'h0000, {8'h00, cnt});
      $display("test events done");
   endtask

   task automatic t_force();
      reload(8'h09);
      cyc(4);
      ctrl(8'h04);
      chk("counter", 16'h0000, {8'h00, cnt});
      chk("control", 16'h0001, {8'h00, ctl});
      ctrl(8'h00);
      $display("test force done");
   endtask

   task automatic t_led();
      d1 = 8'h08;
      pa_cfg = 8'h8a;
      cyc(3);
      chk("pin a", 16'h0003, {14'h0000, pa});
      pa_cfg = 8'h88;
      cyc(3);
      chk("pin a", 16'h0001, {14'h0000, pa});
      pa_cfg = 8'h08;
      pb_cfg = 8'h08;
      d6 = 8'h02;
      cyc(3);
      chk("pin a", 16'h0001, {14'h0000, pa});
      chk("pin b", 16'h0000, {14'h0000, pb});
      d1 = 8'h00;
      pa_cfg = 8'h01;
      cyc(3);
      chk("pin a", 16'h0000, {14'h0000, pa});
      chk("pin b", 16'h0001, {14'h0000, pb});
      d1 = 8'h08;
      pa_cfg = 8'h8a;
      ctrl(8'h02);
      blinks(nb);
      chk("blink", 16'h0004, nb[15:0]);
      ctrl(8'h00);
      cfg.led_tog_on_to = 1'b1;
      blinks(nb);
      chk("blink", 16'h0000, nb[15:0]);
      ctrl(8'h01);
      blinks(nb);
      chk("blink", 16'h0004, nb[15:0]);
      pa_cfg = 8'h82;
      blinks(nb);
      chk("blink", 16'h0000, nb[15:0]);
      chk("pin a", 16'h0001, {14'h0000, pa});
      $display("test led done");
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   initial begin
      cyc(20);
      rst = 1'b0;
      cyc(1);
      t_reset();
      t_count();
      t_events();
      t_force();
      t_led();
      results();
   end
endmodule
